// ### design/itm_map.svh
// Register offsets, field positions and encodings of the interval timer
`ifndef ITM_MAP_SVH
`define ITM_MAP_SVH

// Byte addresses of the four registers
`define ITM_ADDR_W      5
`define ITM_OFS_CH0     5'h18
`define ITM_OFS_CH1     5'h1A
`define ITM_OFS_CH2     5'h1C
`define ITM_OFS_CTRL    5'h1E

// Control word fields
`define ITM_SEL_HI      7
`define ITM_SEL_LO      6
`define ITM_FMT_HI      5
`define ITM_FMT_LO      4
`define ITM_MODE_HI     3
`define ITM_MODE_LO     1
`define ITM_BCD_BIT     0
`define ITM_CFG_HI      5

// Counter select and access format codes
`define ITM_SEL_READBACK 2'h3
`define ITM_FMT_LATCH    2'h0
`define ITM_FMT_LOW      2'h1
`define ITM_FMT_HIGH     2'h2
`define ITM_FMT_LOHI     2'h3

// Read-back command fields
`define ITM_RB_CNT_N    5
`define ITM_RB_STA_N    4
`define ITM_RB_PICK0    1

// Status byte fields
`define ITM_ST_OUT      7
`define ITM_ST_NULL     6

// Fixed values
`define ITM_RD_IDLE     8'h00
`define ITM_CNT_ONE     16'h0001
`define ITM_CNT_ZERO    16'h0000
`define ITM_NUM_CH      3
`define ITM_NUM_SYNC    5

`endif

// ### design/itm_pkg.sv
// Types shared by the interval timer modules
`default_nettype none

package itm_pkg;

	// Decoded operating mode of one counter
	typedef enum logic [2:0] {
		itm_stop_tc,
		itm_one_shot,
		itm_rate,
		itm_square,
		itm_sw_strobe,
		itm_hw_strobe
	} itm_mode_t;

	// Complete state of one counter
	typedef struct packed {
		logic [5:0]  ctrl;   // Access format, mode, decimal select
		logic [15:0] cr;     // Count register written by software
		logic [15:0] ce;     // Counting element
		logic [15:0] ol;     // Hold register for latched count
		logic [7:0]  st;     // Latched status byte
		logic        ol_v;
		logic        st_v;
		logic        wr_hi;  // Next data write is the high byte
		logic        rd_hi;  // Next data read is the high byte
		logic        nc;     // Null-count flag
		logic        out;
		logic        pend;   // Count waits for transfer on next tick
		logic        have;   // A complete count has been written
		logic        run;
		logic        trig;   // Gate rising edge waiting for a tick
		logic        first;  // First tick after a load or reload
	} itm_chan_t;

	// Complete state of the timer top
	typedef struct packed {
		itm_chan_t [2:0] ch;
		logic [7:0]      rd_data;
		logic            o1_d;
		logic            o2_d;
		logic            fire;
	} itm_top_t;

endpackage

`default_nettype wire

// ### design/itm_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`default_nettype none

module itm_sync #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	// Asynchronous inputs
	input  wire logic [W-1:0] din,
	// Filtered level and one-cycle edge pulses
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} itm_sync_t;

	itm_sync_t r;
	itm_sync_t n;
	logic [W-1:0] agree;

	// Level moves only when stages two and three agree
	always_comb begin
		agree  = ~(r.s2 ^ r.s3);
		n      = r;
		n.s1   = din;
		n.s2   = r.s1;
		n.s3   = r.s2;
		n.lvl  = (agree & r.s3) | (~agree & r.lvl);
		n.rise = n.lvl & ~r.lvl;
		n.fall = ~n.lvl & r.lvl;
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign level = r.lvl;
	assign rise  = r.rise;
	assign fall  = r.fall;

endmodule // itm_sync

`default_nettype wire

// ### design/itm_timer.sv
// Three-channel 16-bit interval timer with byte-wide register port
`default_nettype none

`include "itm_map.svh"

module itm_timer (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	// Register port
	input  wire logic [`ITM_ADDR_W-1:0] bus_addr,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	input  wire logic [7:0]             bus_wdata,
	output logic      [7:0]             bus_rdata,
	// Count clock pins
	input  wire logic                   first_counter_ext_clock,
	input  wire logic                   second_counter_clock,
	// Gate pins
	input  wire logic                   first_counter_gate,
	input  wire logic                   second_counter_gate,
	input  wire logic                   third_counter_gate,
	// Counter outputs and pacer trigger
	output logic      [2:0]             counter_out,
	output logic                        conversion_trigger
);

	itm_pkg::itm_top_t r;
	itm_pkg::itm_top_t n;

	logic [`ITM_NUM_SYNC-1:0] sy_lvl;
	logic [`ITM_NUM_SYNC-1:0] sy_rise;
	logic [`ITM_NUM_SYNC-1:0] sy_fall;
	logic [`ITM_NUM_CH-1:0]   tick_v;

	// Pins pass the agreement filter; two clocks then three gates
	itm_sync #(
		.W (`ITM_NUM_SYNC)
	) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.din     ({third_counter_gate, second_counter_gate, first_counter_gate,
		             second_counter_clock, first_counter_ext_clock}),
		.level   (sy_lvl),
		.rise    (sy_rise),
		.fall    (sy_fall)
	);

	// Counter 2 is clocked by the falling output of counter 1
	assign tick_v = {r.o1_d & ~r.ch[1].out, sy_fall[1:0]};

	// One step of binary or decimal decrement, wrapping at zero
	function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
		logic [15:0] t;
		logic        b;
		t = v;
		b = 1'b1;
		if (!bcd) begin
			t = v - `ITM_CNT_ONE;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (b) begin
					if (t[4*k +: 4] == 4'h0) begin
						t[4*k +: 4] = 4'h9;
					end else begin
						t[4*k +: 4] = t[4*k +: 4] - 4'h1;
						b = 1'b0;
					end
				end
			end
		end
		return t;
	endfunction

	// Decrement by one to three steps
	function automatic logic [15:0] dec_n(input logic [15:0] v, input logic [1:0] s,
	                                      input logic bcd);
		logic [15:0] t;
		t = v;
		for (int k = 0; k < 3; k++) begin
			if (2'(k) < s) begin
				t = dec1(t, bcd);
			end
		end
		return t;
	endfunction

	// Mode field to operating mode; top bit ignored for modes 2 and 3
	function automatic itm_pkg::itm_mode_t mode_of(input logic [2:0] m);
		itm_pkg::itm_mode_t md;
		md = itm_pkg::itm_stop_tc;
		if (m[1]) begin
			md = m[0] ? itm_pkg::itm_square : itm_pkg::itm_rate;
		end else begin
			unique case ({m[2], m[0]})
				2'h0: md = itm_pkg::itm_stop_tc;
				2'h1: md = itm_pkg::itm_one_shot;
				2'h2: md = itm_pkg::itm_sw_strobe;
				2'h3: md = itm_pkg::itm_hw_strobe;
			endcase
		end
		return md;
	endfunction

	// Data register address of a counter
	function automatic logic [`ITM_ADDR_W-1:0] ch_ofs(input int i);
		logic [`ITM_ADDR_W-1:0] a;
		unique case (i)
			0:       a = `ITM_OFS_CH0;
			1:       a = `ITM_OFS_CH1;
			default: a = `ITM_OFS_CH2;
		endcase
		return a;
	endfunction

	itm_pkg::itm_chan_t c;
	itm_pkg::itm_mode_t md;
	logic [1:0]         step;
	logic [1:0]         sel;
	logic [7:0]         d;
	logic [15:0]        v;
	logic               gate;
	logic               trig_mode;
	logic               gate_ok;
	logic               done;
	logic               wr_ctrl;

	// Next state of all counters and of the read port
	always_comb begin
		n         = r;
		c         = r.ch[0];
		md        = itm_pkg::itm_stop_tc;
		step      = 2'h2;
		d         = bus_wdata;
		sel       = bus_wdata[`ITM_SEL_HI:`ITM_SEL_LO];
		v         = `ITM_CNT_ZERO;
		gate      = 1'b0;
		trig_mode = 1'b0;
		gate_ok   = 1'b0;
		done      = 1'b0;
		wr_ctrl   = bus_wr & (bus_addr == `ITM_OFS_CTRL);
		n.o1_d    = r.ch[1].out;
		n.o2_d    = r.ch[2].out;
		// Pacer fires on each rising edge of counter 2 output
		n.fire    = r.ch[2].out & ~r.o2_d;
		// Reads of the control or unmapped addresses return zero
		if (bus_rd) begin
			n.rd_data = `ITM_RD_IDLE;
		end
		for (int i = 0; i < `ITM_NUM_CH; i++) begin
			c         = r.ch[i];
			md        = mode_of(c.ctrl[`ITM_MODE_HI:`ITM_MODE_LO]);
			gate      = sy_lvl[2+i];
			trig_mode = (md != itm_pkg::itm_stop_tc) && (md != itm_pkg::itm_sw_strobe);
			// Modes 1 and 5 are edge-triggered and ignore the gate level
			gate_ok   = gate || (md == itm_pkg::itm_one_shot) ||
			            (md == itm_pkg::itm_hw_strobe);
			done      = 1'b0;
			// Count clock tick: trigger, pending load, or one count step
			if (tick_v[i]) begin
				if (c.trig && c.have && trig_mode) begin
					c.ce    = c.cr;
					c.nc    = 1'b1;
					c.run   = 1'b1;
					c.first = 1'b1;
					c.trig  = 1'b0;
					c.pend  = 1'b0;
					if (md == itm_pkg::itm_one_shot) begin
						c.out = 1'b0;
					end
				end else if (c.pend && !trig_mode || c.pend && gate_ok) begin
					c.ce    = c.cr;
					c.nc    = 1'b1;
					c.run   = 1'b1;
					c.first = 1'b1;
					c.pend  = 1'b0;
				end else if (c.run && gate_ok) begin
					unique case (md)
						itm_pkg::itm_stop_tc: begin
							// Keeps decrementing past terminal count
							c.ce = dec1(c.ce, c.ctrl[`ITM_BCD_BIT]);
							if (c.ce == `ITM_CNT_ZERO) begin
								c.out = 1'b1;
							end
						end
						itm_pkg::itm_one_shot: begin
							c.ce = dec1(c.ce, c.ctrl[`ITM_BCD_BIT]);
							if (c.ce == `ITM_CNT_ZERO) begin
								c.out = 1'b1;
								c.run = 1'b0;
							end
						end
						itm_pkg::itm_rate: begin
							if (!c.out) begin
								c.out = 1'b1;
								c.ce  = c.cr;
								c.nc  = 1'b1;
							end else begin
								c.ce = dec1(c.ce, c.ctrl[`ITM_BCD_BIT]);
								if (c.ce == `ITM_CNT_ONE) begin
									c.out = 1'b0;
								end
							end
						end
						itm_pkg::itm_square: begin
							// Odd count: 1 on high start, 3 on low start
							if (c.first && c.ce[0]) begin
								step = c.out ? 2'h1 : 2'h3;
							end else begin
								step = 2'h2;
							end
							c.first = 1'b0;
							if (c.ce <= {14'h0000, step}) begin
								c.out   = ~c.out;
								c.ce    = c.cr;
								c.nc    = 1'b1;
								c.first = 1'b1;
							end else begin
								c.ce = dec_n(c.ce, step, c.ctrl[`ITM_BCD_BIT]);
							end
						end
						default: begin
							// Strobe modes: one low clock, then stop counting
							if (!c.out) begin
								c.out = 1'b1;
								c.run = 1'b0;
							end else begin
								c.ce = dec1(c.ce, c.ctrl[`ITM_BCD_BIT]);
								if (c.ce == `ITM_CNT_ZERO) begin
									c.out = 1'b0;
								end
							end
						end
					endcase
				end
			end
			// Low gate holds the output high in the periodic modes
			if (!gate && (md == itm_pkg::itm_rate || md == itm_pkg::itm_square)) begin
				c.out = 1'b1;
			end
			// Control word: latch, program or read-back
			if (wr_ctrl) begin
				if (sel == `ITM_SEL_READBACK) begin
					if (bus_wdata[`ITM_RB_PICK0+i]) begin
						if (!bus_wdata[`ITM_RB_CNT_N] && !c.ol_v) begin
							c.ol   = c.ce;
							c.ol_v = 1'b1;
						end
						if (!bus_wdata[`ITM_RB_STA_N] && !c.st_v) begin
							c.st   = {c.out, c.nc, c.ctrl};
							c.st_v = 1'b1;
						end
					end
				end else if (sel == 2'(i)) begin
					if (bus_wdata[`ITM_FMT_HI:`ITM_FMT_LO] == `ITM_FMT_LATCH) begin
						// A second latch before reading is ignored
						if (!c.ol_v) begin
							c.ol   = c.ce;
							c.ol_v = 1'b1;
						end
					end else begin
						c.ctrl  = bus_wdata[`ITM_CFG_HI:0];
						c.out   = mode_of(bus_wdata[`ITM_MODE_HI:`ITM_MODE_LO]) !=
						          itm_pkg::itm_stop_tc;
						c.run   = 1'b0;
						c.pend  = 1'b0;
						c.have  = 1'b0;
						c.trig  = 1'b0;
						c.wr_hi = 1'b0;
						c.rd_hi = 1'b0;
						c.ol_v  = 1'b0;
						c.st_v  = 1'b0;
						c.nc    = 1'b0;
					end
				end
			end
			// Gate edge after tick and control word, so a new edge wins unless the counter was in mode 0 or 4 before the control word
			if (sy_rise[2+i] && trig_mode) begin
				c.trig = 1'b1;
			end
			// Count write; ignored until the counter has been programmed
			if (bus_wr && bus_addr == ch_ofs(i)) begin
				unique case (c.ctrl[`ITM_FMT_HI:`ITM_FMT_LO])
					`ITM_FMT_LOW: begin
						c.cr = {8'h00, d};
						done = 1'b1;
					end
					`ITM_FMT_HIGH: begin
						c.cr = {d, 8'h00};
						done = 1'b1;
					end
					`ITM_FMT_LOHI: begin
						if (!c.wr_hi) begin
							c.cr[7:0] = d;
							c.wr_hi   = 1'b1;
							if (md == itm_pkg::itm_stop_tc) begin
								c.run = 1'b0;
								c.pend = 1'b0;
							end
						end else begin
							c.cr[15:8] = d;
							c.wr_hi    = 1'b0;
							done       = 1'b1;
						end
					end
					default: begin
					end
				endcase
				if (done) begin
					c.nc   = 1'b0;
					c.have = 1'b1;
					// Periodic modes keep the running period; one-shot and hardware strobe need a trigger
					if (md == itm_pkg::itm_stop_tc || md == itm_pkg::itm_sw_strobe ||
					    (!c.run && (md == itm_pkg::itm_rate || md == itm_pkg::itm_square))) begin
						c.pend = 1'b1;
					end
					if (md == itm_pkg::itm_stop_tc) begin
						c.out = 1'b0;
					end
				end
			end
			// Data read: latched status first, then held or live count
			if (bus_rd && bus_addr == ch_ofs(i)) begin
				v = c.ol_v ? c.ol : c.ce;
				if (c.st_v) begin
					n.rd_data = c.st;
					c.st_v    = 1'b0;
				end else begin
					unique case (c.ctrl[`ITM_FMT_HI:`ITM_FMT_LO])
						`ITM_FMT_LOW: begin
							n.rd_data = v[7:0];
							c.ol_v    = 1'b0;
						end
						`ITM_FMT_HIGH: begin
							n.rd_data = v[15:8];
							c.ol_v    = 1'b0;
						end
						`ITM_FMT_LOHI: begin
							if (!c.rd_hi) begin
								n.rd_data = v[7:0];
								c.rd_hi   = 1'b1;
							end else begin
								n.rd_data = v[15:8];
								c.rd_hi   = 1'b0;
								c.ol_v    = 1'b0;
							end
						end
						default: begin
							n.rd_data = `ITM_RD_IDLE;
						end
					endcase
				end
			end
			n.ch[i] = c;
		end
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign bus_rdata          = r.rd_data;
	assign counter_out        = {r.ch[2].out, r.ch[1].out, r.ch[0].out};
	assign conversion_trigger = r.fire;

endmodule // itm_timer

`default_nettype wire

// ### verification/itm_timer_chk.sv
// Port-level assertions for the interval timer
`default_nettype none
`include "itm_map.svh"
module itm_timer_chk (
	// Clock and reset
	input wire logic                   clock,
	input wire logic                   reset_n,
	// Register port
	input wire logic [`ITM_ADDR_W-1:0] bus_addr,
	input wire logic                   bus_wr,
	input wire logic                   bus_rd,
	input wire logic [7:0]             bus_wdata,
	input wire logic [7:0]             bus_rdata,
	// Pins
	input wire logic                   first_counter_ext_clock,
	input wire logic                   second_counter_clock,
	input wire logic                   first_counter_gate,
	input wire logic                   second_counter_gate,
	input wire logic                   third_counter_gate,
	input wire logic [2:0]             counter_out,
	input wire logic                   conversion_trigger
);
	// Control word that programs counter 0; latch commands excluded
	wire logic ctl0 = bus_wr && bus_addr == `ITM_OFS_CTRL && bus_wdata[7:6] == 2'h0
		&& bus_wdata[5:4] != 2'h0;
	// Reads that never reach a counter
	wire logic rd_zero = bus_rd && !(bus_addr inside {`ITM_OFS_CH0, `ITM_OFS_CH1, `ITM_OFS_CH2});
	logic [2:0] mode0_r;

	// Mode of counter 0 as seen on the bus, so gate checks know the mode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode0_r <= 3'h0;
		end else if (ctl0) begin
			mode0_r <= bus_wdata[3:1];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Steps of the behaviours checked below
	sequence s_rise2;
		!counter_out[2] ##1 counter_out[2];
	endsequence
	sequence s_gate0_low;
		!first_counter_gate [*8];
	endsequence

	property p_trig_after_rise;
		s_rise2 |-> ##1 conversion_trigger;
	endproperty
	a_trig_after_rise: assert property (p_trig_after_rise) else $error("no trigger after rise");
	property p_trig_cause;
		conversion_trigger |-> $past(counter_out[2]) && !$past(counter_out[2], 2);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without rise");
	property p_trig_pulse;
		conversion_trigger |=> !conversion_trigger;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
	property p_rdata_hold;
		!bus_rd |=> $stable(bus_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_ctrl_read;
		rd_zero |=> bus_rdata == 8'h00;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read not zero");
	property p_mode0_low;
		ctl0 && bus_wdata[3:1] == 3'h0 |-> ##[1:3] !counter_out[0];
	endproperty
	a_mode0_low: assert property (p_mode0_low) else $error("mode 0 output not low");
	property p_mode_high;
		ctl0 && bus_wdata[3:1] != 3'h0 |-> ##[1:3] counter_out[0];
	endproperty
	a_mode_high: assert property (p_mode_high) else $error("output not high at setup");
	property p_gate_force;
		s_gate0_low ##0 (mode0_r[1:0] == 2'h2) |-> counter_out[0];
	endproperty
	a_gate_force: assert property (p_gate_force) else $error("low gate not forcing high");
endmodule // itm_timer_chk

bind itm_timer itm_timer_chk u_chk (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.first_counter_ext_clock(first_counter_ext_clock), .second_counter_clock(second_counter_clock),
	.first_counter_gate(first_counter_gate), .second_counter_gate(second_counter_gate),
	.third_counter_gate(third_counter_gate), .counter_out(counter_out),
	.conversion_trigger(conversion_trigger));
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the interval timer
`default_nettype none
`include "itm_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock, reset_n, bus_wr, bus_rd, ck0, ck1, g0, g1, g2, trig;
	logic [4:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata;
	logic [2:0] cout;
	logic       obs [0:23];
	int         n_errors, checked, n_trig;

	itm_timer u_dut (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.first_counter_ext_clock(ck0), .second_counter_clock(ck1), .first_counter_gate(g0),
		.second_counter_gate(g1), .third_counter_gate(g2), .counter_out(cout),
		.conversion_trigger(trig));

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Trigger pulses counted away from the launching edge
	always @(negedge clock) begin
		if (trig === 1'b1) n_trig++;
	end
	// Watchdog sized well above the whole sequence
	initial begin
		#100us;
		n_errors++;
		test_done();
	end

	task automatic test_done();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Idle cycle after each strobe so it is never reassigned in one step
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		cyc(1);
		bus_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		bus_addr = a;
		bus_rd = 1'b1;
		cyc(1);
		bus_rd = 1'b0;
		cmp(bus_rdata, exp);
		cyc(1);
	endtask
	task automatic load0(input logic [15:0] c);
		wr(`ITM_OFS_CH0, c[7:0]);
		wr(`ITM_OFS_CH0, c[15:8]);
	endtask
	// Count clock periods; each level held four clocks, just as long as the synchroniser takes to pass it
	task automatic ticks(input int n, input bit pin);
		for (int i = 0; i < n; i++) begin
			if (pin) ck1 = 1'b0; else ck0 = 1'b0;
			cyc(4);
			if (pin) ck1 = 1'b1; else ck0 = 1'b1;
			cyc(4);
			if (i < 24) obs[i] = cout[0];
		end
	endtask
	// First complete low run of counter 0 and the high run after it
	task automatic runs(output int h, output int l);
		int k;
		k = 3;
		h = 0;
		l = 0;
		while (k < 24 && !(obs[k-1] === 1'b1 && obs[k] === 1'b0)) k++;
		while (k < 24 && obs[k] === 1'b0) begin
			l++;
			k++;
		end
		while (k < 24 && obs[k] === 1'b1) begin
			h++;
			k++;
		end
	endtask

	task automatic t_idle();
		rd(`ITM_OFS_CTRL, 8'h00);
		rd(5'h00, 8'h00);
		wr(`ITM_OFS_CH0, 8'h55);
		rd(`ITM_OFS_CH0, 8'h00);
	endtask
	task automatic t_latch();
		g0 = 1'b1;
		wr(`ITM_OFS_CTRL, 8'h30);
		load0(16'h1234);
		wr(`ITM_OFS_CTRL, 8'hE2);
		rd(`ITM_OFS_CH0, 8'h30);
		ticks(1, 1'b0);
		wr(`ITM_OFS_CTRL, 8'h00);
		ticks(3, 1'b0);
		rd(`ITM_OFS_CH0, 8'h34);
		rd(`ITM_OFS_CH0, 8'h12);
		wr(`ITM_OFS_CTRL, 8'hC2);
		rd(`ITM_OFS_CH0, 8'h70);
		rd(`ITM_OFS_CH0, 8'h31);
		rd(`ITM_OFS_CH0, 8'h12);
		cmp(8'(cout[0]), 8'h00);
		wr(`ITM_OFS_CH0, 8'h05);
		ticks(2, 1'b0);
		wr(`ITM_OFS_CTRL, 8'h00);
		rd(`ITM_OFS_CH0, 8'h31);
		rd(`ITM_OFS_CH0, 8'h12);
		wr(`ITM_OFS_CH0, 8'h00);
		ticks(5, 1'b0);
		cmp(8'(cout[0]), 8'h00);
		ticks(1, 1'b0);
		cmp(8'(cout[0]), 8'h01);
	endtask
	// Single-byte formats: low byte, then high byte
	task automatic t_fmt();
		logic [7:0] cw [2] = '{8'h10, 8'h20};
		for (int i = 0; i < 2; i++) begin
			wr(`ITM_OFS_CTRL, cw[i]);
			wr(`ITM_OFS_CH0, 8'h07);
			ticks(1, 1'b0);
			wr(`ITM_OFS_CTRL, 8'h00);
			rd(`ITM_OFS_CH0, 8'h07);
		end
	endtask
	task automatic t_gate();
		g0 = 1'b0;
		wr(`ITM_OFS_CTRL, 8'h30);
		load0(16'h0002);
		ticks(4, 1'b0);
		cmp(8'(cout[0]), 8'h00);
		g0 = 1'b1;
		ticks(3, 1'b0);
		cmp(8'(cout[0]), 8'h01);
	endtask
	task automatic t_wave();
		logic [7:0]  cw [5] = '{8'h34, 8'h35, 8'h3C, 8'h36, 8'h36};
		logic [15:0] cn [5] = '{16'h0005, 16'h0010, 16'h0005, 16'h0004, 16'h0005};
		int          eh [5] = '{4, 9, 4, 2, 3};
		int          el [5] = '{1, 1, 1, 2, 2};
		int          h, l;
		g0 = 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr(`ITM_OFS_CTRL, cw[i]);
			cmp(8'(cout[0]), 8'h01);
			load0(cn[i]);
			ticks(24, 1'b0);
			runs(h, l);
			cmp(8'(h), 8'(eh[i]));
			cmp(8'(l), 8'(el[i]));
			if (i == 0) begin
				g0 = 1'b0;
				cyc(12);
				cmp(8'(cout[0]), 8'h01);
				g0 = 1'b1;
			end
		end
	endtask
	// Strobes and one-shot, the last two started by a gate rise
	task automatic t_strobe();
		logic [7:0] cw [3] = '{8'h38, 8'h32, 8'h3A};
		int         el [3] = '{1, 3, 1};
		int         c;
		for (int i = 0; i < 3; i++) begin
			g0 = (i == 0);
			wr(`ITM_OFS_CTRL, cw[i]);
			cmp(8'(cout[0]), 8'h01);
			load0((i == 0) ? 16'h0002 : 16'h0003);
			g0 = 1'b1;
			cyc(6);
			ticks(8, 1'b0);
			c = 0;
			for (int j = 0; j < 8; j++) c += (obs[j] === 1'b0);
			cmp(8'(c), 8'(el[i]));
			if (i == 0) cmp(8'(obs[2]), 8'h00);
		end
	endtask
	task automatic t_chain();
		g1 = 1'b1;
		g2 = 1'b1;
		wr(`ITM_OFS_CTRL, 8'h74);
		wr(`ITM_OFS_CH1, 8'h02);
		wr(`ITM_OFS_CH1, 8'h00);
		wr(`ITM_OFS_CTRL, 8'hB6);
		wr(`ITM_OFS_CH2, 8'h02);
		wr(`ITM_OFS_CH2, 8'h00);
		cyc(4);
		n_trig = 0;
		ticks(16, 1'b1);
		cyc(8);
		cmp(8'(n_trig), 8'h03);
		cmp(8'(cout[2:1]), 8'h00);
		wr(`ITM_OFS_CTRL, 8'hCC);
		rd(`ITM_OFS_CH2, 8'h76);
		rd(`ITM_OFS_CH2, 8'h02);
		rd(`ITM_OFS_CH2, 8'h00);
		rd(`ITM_OFS_CH1, 8'h74);
		rd(`ITM_OFS_CH1, 8'h01);
		rd(`ITM_OFS_CH1, 8'h00);
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 5'h00;
		bus_wdata = 8'h00;
		ck0 = 1'b1;
		ck1 = 1'b1;
		g0 = 1'b0;
		g1 = 1'b0;
		g2 = 1'b0;
		cyc(6);
		reset_n = 1'b1;
		cyc(1);
		t_idle();
		t_latch();
		t_fmt();
		t_gate();
		t_wave();
		t_strobe();
		t_chain();
		test_done();
	end
endmodule // tb
`default_nettype wire
